// *** src/twe_pkg.sv ***
// constants and types for the timer, watchdog and interrupt block
package twe_pkg;

   // register byte offsets
   localparam logic [7:0] A_T0MODE = 8'h00;
   localparam logic [7:0] A_T1MODE = 8'h04;
   localparam logic [7:0] A_T0LOW  = 8'h08;
   localparam logic [7:0] A_T0HIGH = 8'h0c;
   localparam logic [7:0] A_T1LOW  = 8'h10;
   localparam logic [7:0] A_T1HIGH = 8'h14;
   localparam logic [7:0] A_EVF    = 8'h18;
   localparam logic [7:0] A_IEF    = 8'h1c;
   localparam logic [7:0] A_HEF    = 8'h20;
   localparam logic [7:0] A_PEF    = 8'h24;
   localparam logic [7:0] A_SCR    = 8'h28;
   localparam logic [7:0] A_CMD    = 8'h2c;
   localparam logic [7:0] A_STAT   = 8'h30;

   // field positions
   localparam int MODE_SEL = 0;
   localparam int T1_SRC   = 1;
   localparam int T1_MFP   = 2;
   localparam int MODE_RUN = 3;
   localparam int SCR_WD   = 2;

   // prescale and watchdog counter terminal counts
   localparam logic [9:0]  T0_DIV_FAST = 10'h003;
   localparam logic [9:0]  T0_DIV_SLOW = 10'h3ff;
   localparam logic [5:0]  T1_DIV64    = 6'h3f;
   localparam logic [9:0]  WD_DIV_FAST = 10'h3ff;
   localparam logic [13:0] WD_DIV_SLOW = 14'h3fff;
   localparam logic [3:0]  WD_TOP      = 4'hf;

   // vectors and reset values
   localparam logic [7:0] VEC_BASE  = 8'h04;
   localparam logic [7:0] RST_BYTE  = 8'h00;
   localparam logic [3:0] RST_NIB   = 4'h0;
   localparam logic       RST_INHIB = 1'b1;

   typedef struct packed {
      logic hold_enter;
      logic ret;
      logic gdis;
      logic gen;
      logic wclr;
   } twe_cmd_t;

   typedef struct packed {
      logic [7:0] vector;
      logic       hold;
      logic       inhibit;
      logic       t1_run;
      logic       t0_run;
      logic [3:0] wd;
      logic [7:0] t1_cnt;
      logic [7:0] t0_cnt;
   } twe_stat_t;

endpackage

// *** src/twe_timers.sv ***
// watchdog, two timers, event flags, interrupts and hold
// Function
// - watchdog is a 4-bit up-counter; overflow resets the chip
// - watchdog acts only when the mask option enables it
// - watchdog ticks at clock/1024, or clock/16384 with clock control bit 2
// - watchdog clear command zeroes the counter; software clears it in time
// - timer 0 load nibble write stops it, clears run, loads value
// - timer 0 run set clears event flag 1 and starts counting
// - timer 0 stops and sets event flag 1 on wrap to ff
// - timer 0 underflow requests interrupt and hold release if enabled
// - timer 0 mode bit 0 picks clock/4 or clock/1024
// - timer 0 interval is preset plus one times prescale
// - timer 1 nibble write fills reload buffer and clears run
// - timer 1 run set loads buffer, starts, clears event flag 7
// - timer 1 wrap sets event flag 7, reloads, keeps counting
// - timer 1 underflow requests interrupt and hold release if enabled
// - timer 1 mode bit 0 picks clock or clock/64
// - timer 1 mode bit 1 picks internal tick or sub-oscillator
// - timer 1 mode bit 2 routes timer 1 square wave to pin when set, generator when clear
// - interrupt needs flag plus enable; port source needs port enable
// - taken interrupt clears its flag and inhibits until re-enabled
// - global disable blocks interrupts until re-enabled
// - vectors lie from 004h through 020h, one per source
// - interrupt in hold leaves hold, returns to hold after return
// - enable bits 0..7 map to the eight listed sources
`timescale 1ns/1ps
`default_nettype none
module twe_timers
   import twe_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        watchdog_option,
   input  wire logic        sub_osc_clock,
   input  wire logic        mfp_generator,
   input  wire logic [4:0]  source_pulse,
   input  wire logic [3:0]  port_c_change,
   output logic             chip_reset,
   output logic             irq_take,
   output logic [7:0]       irq_vector,
   output logic             hold_active,
   output logic             multi_function_output_pin
);

   logic        pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic        opt1_q, opt2_q;
   logic        so1_q, so2_q, so3_q;
   logic        gen1_q, gen2_q;
   logic [13:0] wd_pre_q;
   logic [3:0]  watchdog_counter_q;
   logic        chip_reset_q;
   logic [7:0]  system_clock_control_q;
   logic        t0_sel_q, t0_run_q;
   logic [9:0]  t0_pre_q;
   logic [7:0]  timer_zero_q;
   logic        t1_div_q, t1_src_q, t1_mfp_q, t1_run_q;
   logic [5:0]  t1_pre_q;
   logic [7:0]  t1_buf_q, timer_one_q;
   logic        tone_q, mfp_q;
   logic [7:0]  event_flags_q, irq_enable_bits_q;
   logic [7:0]  hold_release_enables_q, port_event_enables_q;
   logic [7:0]  event_flags_d;
   logic        inhib_q, irq_q, hold_q, rehold_q;
   logic [7:0]  vec_q;

   // bus decode
   wire acc   = psel & penable & pready_q;
   wire wr    = acc & pwrite;
   wire ans   = psel & penable & ~pready_q;
   wire h_t0m = paddr == A_T0MODE;
   wire h_t1m = paddr == A_T1MODE;
   wire h_t0l = paddr == A_T0LOW;
   wire h_t0h = paddr == A_T0HIGH;
   wire h_t1l = paddr == A_T1LOW;
   wire h_t1h = paddr == A_T1HIGH;
   wire h_evf = paddr == A_EVF;
   wire h_ief = paddr == A_IEF;
   wire h_hef = paddr == A_HEF;
   wire h_pef = paddr == A_PEF;
   wire h_scr = paddr == A_SCR;
   wire h_cmd = paddr == A_CMD;
   wire h_st  = paddr == A_STAT;
   wire mapped = h_t0m | h_t1m | h_t0l | h_t0h | h_t1l | h_t1h |
                 h_evf | h_ief | h_hef | h_pef | h_scr | h_cmd | h_st;
   wire [7:0] wb = pwdata[7:0];
   wire [3:0] wn = pwdata[3:0];

   twe_cmd_t  cmd;
   twe_stat_t stat;
   assign cmd = (wr & h_cmd) ? twe_cmd_t'(pwdata[4:0]) : '0;
   assign stat = '{vector: vec_q, hold: hold_q, inhibit: inhib_q,
                   t1_run: t1_run_q, t0_run: t0_run_q,
                   wd: watchdog_counter_q, t1_cnt: timer_one_q,
                   t0_cnt: timer_zero_q};

   wire [31:0] rd_mux =
      h_evf ? {24'h000000, event_flags_q} :
      h_ief ? {24'h000000, irq_enable_bits_q} :
      h_hef ? {24'h000000, hold_release_enables_q} :
      h_pef ? {24'h000000, port_event_enables_q} :
      h_scr ? {24'h000000, system_clock_control_q} :
      h_st  ? 32'(stat) : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= ans;
         pslverr_q <= ans & ~mapped;
         if (ans) begin
            prdata_q <= rd_mux;
         end
      end
   end

   // pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opt1_q <= 1'b0;
         opt2_q <= 1'b0;
         so1_q  <= 1'b0;
         so2_q  <= 1'b0;
         so3_q  <= 1'b0;
         gen1_q <= 1'b0;
         gen2_q <= 1'b0;
      end else begin
         opt1_q <= watchdog_option;
         opt2_q <= opt1_q;
         so1_q  <= sub_osc_clock;
         so2_q  <= so1_q;
         so3_q  <= so2_q;
         gen1_q <= mfp_generator;
         gen2_q <= gen1_q;
      end
   end

   // watchdog
   wire wd_tick = system_clock_control_q[SCR_WD] ?
                  (wd_pre_q == WD_DIV_SLOW) :
                  (wd_pre_q[9:0] == WD_DIV_FAST);
   wire wd_step = wd_tick & opt2_q;
   wire wd_ovf  = wd_step & (watchdog_counter_q == WD_TOP);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_pre_q               <= 14'h0000;
         watchdog_counter_q     <= RST_NIB;
         chip_reset_q           <= 1'b0;
         system_clock_control_q <= RST_BYTE;
      end else begin
         wd_pre_q     <= wd_pre_q + 14'h0001;
         chip_reset_q <= wd_ovf;
         if (wd_ovf) begin
            watchdog_counter_q <= RST_NIB;
         end else if (cmd.wclr) begin
            watchdog_counter_q <= RST_NIB;
         end else if (wd_step) begin
            watchdog_counter_q <= watchdog_counter_q + 4'h1;
         end
         if (wd_ovf) begin
            system_clock_control_q[SCR_WD] <= 1'b0;
         end else if (wr & h_scr) begin
            system_clock_control_q <= wb;
         end
      end
   end

   // timer zero
   wire t0_mw   = wr & h_t0m;
   wire t0_ld   = wr & (h_t0l | h_t0h);
   wire t0_go   = t0_mw & pwdata[MODE_RUN];
   wire [9:0] t0_lim = t0_sel_q ? T0_DIV_SLOW : T0_DIV_FAST;
   wire t0_tick = t0_run_q & (t0_pre_q == t0_lim);
   wire t0_uf   = t0_tick & (timer_zero_q == 8'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t0_sel_q     <= 1'b0;
         t0_run_q     <= 1'b0;
         t0_pre_q     <= 10'h000;
         timer_zero_q <= RST_BYTE;
      end else begin
         if (t0_mw) begin
            t0_sel_q <= pwdata[MODE_SEL];
         end
         if (t0_ld) begin
            t0_run_q <= 1'b0;
         end else if (t0_mw) begin
            t0_run_q <= pwdata[MODE_RUN];
         end else if (t0_uf) begin
            t0_run_q <= 1'b0;
         end
         if (t0_ld | t0_go | ~t0_run_q | t0_tick) begin
            t0_pre_q <= 10'h000;
         end else begin
            t0_pre_q <= t0_pre_q + 10'h001;
         end
         if (wr & h_t0l) begin
            timer_zero_q <= {timer_zero_q[7:4], wn};
         end else if (wr & h_t0h) begin
            timer_zero_q <= {wn, timer_zero_q[3:0]};
         end else if (t0_tick) begin
            timer_zero_q <= timer_zero_q - 8'h01;
         end
      end
   end

   // timer one
   wire t1_mw   = wr & h_t1m;
   wire t1_ld   = wr & (h_t1l | h_t1h);
   wire t1_go   = t1_mw & pwdata[MODE_RUN];
   wire so_edge = so2_q & ~so3_q;
   wire t1_int  = t1_div_q ? (t1_pre_q == T1_DIV64) : 1'b1;
   wire t1_tick = t1_run_q & (t1_src_q ? so_edge : t1_int);
   wire t1_uf   = t1_tick & (timer_one_q == 8'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t1_div_q    <= 1'b0;
         t1_src_q    <= 1'b0;
         t1_mfp_q    <= 1'b0;
         t1_run_q    <= 1'b0;
         t1_pre_q    <= 6'h00;
         t1_buf_q    <= RST_BYTE;
         timer_one_q <= RST_BYTE;
         tone_q      <= 1'b0;
         mfp_q       <= 1'b0;
      end else begin
         if (t1_mw) begin
            t1_div_q <= pwdata[MODE_SEL];
            t1_src_q <= pwdata[T1_SRC];
            t1_mfp_q <= pwdata[T1_MFP];
         end
         if (t1_ld) begin
            t1_run_q <= 1'b0;
         end else if (t1_mw) begin
            t1_run_q <= pwdata[MODE_RUN];
         end
         if (t1_go | ~t1_run_q | (t1_div_q & t1_int)) begin
            t1_pre_q <= 6'h00;
         end else begin
            t1_pre_q <= t1_pre_q + 6'h01;
         end
         if (wr & h_t1l) begin
            t1_buf_q <= {t1_buf_q[7:4], wn};
         end else if (wr & h_t1h) begin
            t1_buf_q <= {wn, t1_buf_q[3:0]};
         end
         if (t1_go | t1_uf) begin
            timer_one_q <= t1_buf_q;
         end else if (t1_tick) begin
            timer_one_q <= timer_one_q - 8'h01;
         end
         if (t1_uf) begin
            tone_q <= ~tone_q;
         end
         mfp_q <= t1_mfp_q ? tone_q : gen2_q;
      end
   end

   // event flags and interrupt selection
   wire portc = |(port_c_change & port_event_enables_q[3:0]);
   wire [7:0] ev_set = {t1_uf, source_pulse[4], source_pulse[3],
                        source_pulse[2], source_pulse[1], portc,
                        t0_uf, source_pulse[0]};
   wire [7:0] pend = event_flags_q & irq_enable_bits_q;
   wire take = ~inhib_q & (|pend);
   logic [2:0] idx;
   always_comb begin
      idx = 3'd0;
      for (int i = 7; i >= 0; i--) begin
         if (pend[i]) begin
            idx = 3'(i);
         end
      end
   end
   wire [7:0] take_mask = take ? (8'h01 << idx) : 8'h00;
   wire [7:0] vec = VEC_BASE + {3'b000, idx, 2'b00};
   wire [7:0] ev_clr = ((wr & h_evf) ? wb : 8'h00) | take_mask |
                       {t1_go, 5'b00000, t0_go, 1'b0};
   assign event_flags_d = (event_flags_q & ~ev_clr) | ev_set;
   wire rel = |(ev_set & hold_release_enables_q);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_flags_q          <= RST_BYTE;
         irq_enable_bits_q      <= RST_BYTE;
         hold_release_enables_q <= RST_BYTE;
         port_event_enables_q   <= RST_BYTE;
         inhib_q                <= RST_INHIB;
         irq_q                  <= 1'b0;
         vec_q                  <= RST_BYTE;
      end else begin
         event_flags_q <= event_flags_d;
         if (wr & h_ief) begin
            irq_enable_bits_q <= wb;
         end
         if (wr & h_hef) begin
            hold_release_enables_q <= wb;
         end
         if (wr & h_pef) begin
            port_event_enables_q <= wb;
         end
         if (take | cmd.gdis) begin
            inhib_q <= 1'b1;
         end else if (cmd.gen | (wr & h_ief)) begin
            inhib_q <= 1'b0;
         end
         irq_q <= take;
         if (take) begin
            vec_q <= vec;
         end
      end
   end

   // hold control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q   <= 1'b0;
         rehold_q <= 1'b0;
      end else begin
         if (take & hold_q) begin
            hold_q   <= 1'b0;
            rehold_q <= 1'b1;
         end else if (rel) begin
            hold_q   <= 1'b0;
            rehold_q <= 1'b0;
         end else if (cmd.ret & rehold_q) begin
            hold_q   <= 1'b1;
            rehold_q <= 1'b0;
         end else if (cmd.hold_enter) begin
            hold_q <= 1'b1;
         end
      end
   end

   assign prdata                    = prdata_q;
   assign pready                    = pready_q;
   assign pslverr                   = pslverr_q;
   assign chip_reset                = chip_reset_q;
   assign irq_take                  = irq_q;
   assign irq_vector                = vec_q;
   assign hold_active               = hold_q;
   assign multi_function_output_pin = mfp_q;

endmodule
`default_nettype wire

// *** dv/twe_checker.sv ***
// port assertions for the timer, watchdog and interrupt block
`timescale 1ns/1ps
`default_nettype none
module twe_checker
   import twe_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        watchdog_option,
   input wire logic        chip_reset,
   input wire logic        irq_take,
   input wire logic [7:0]  irq_vector,
   input wire logic        hold_active
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      !pready ##1 pready;
   endsequence
   apb_answer_a: assert property (setup_s |=> answer_s)
      else $error("apb answer not in second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read data not zero");
   take_pulse_a: assert property (irq_take |=> !irq_take)
      else $error("interrupt taken twice in a row");
   vec_range_a: assert property (irq_take |=> irq_vector >= VEC_BASE
      && irq_vector <= 8'h20 && irq_vector[1:0] == 2'b00)
      else $error("vector outside table");
   take_hold_a: assert property (irq_take |-> !hold_active)
      else $error("hold kept while servicing");
   wd_gated_a: assert property (!watchdog_option [*5] |-> !chip_reset)
      else $error("watchdog reset while not enabled");
   rst_pulse_a: assert property (chip_reset |=> !chip_reset)
      else $error("chip reset longer than one cycle");
endmodule
`default_nettype wire

// *** dv/twe_cpu.sv ***
// cpu side model issuing register transfers
`timescale 1ns/1ps
`default_nettype none
module twe_cpu
   import twe_pkg::*;
(
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic [31:0] rdat;
   logic        rerr;
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wd_clear;
      xfer(1'b1, A_CMD, 32'h1);
   endtask
endmodule
`default_nettype wire

// *** dv/test_timers_watchdog_irq_events.sv ***
// self-checking bench for the timer, watchdog and interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_timers_watchdog_irq_events import twe_pkg::*;;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, irq_vector;
   logic [31:0] pwdata, prdata;
   logic        watchdog_option = 1'b0;
   logic        sub_osc_clock = 1'b0;
   logic        mfp_generator = 1'b0;
   logic [4:0]  source_pulse = 5'h00;
   logic [3:0]  port_c_change = 4'h0;
   logic        chip_reset, irq_take, hold_active, pin;
   logic [31:0] rnd = 32'h86ae81e2;
   int          n_errors = 0, checked = 0, n_take = 0, n_rst = 0, cyc = 0;
   twe_timers u_twe_timers (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .watchdog_option(watchdog_option), .sub_osc_clock(sub_osc_clock),
      .mfp_generator(mfp_generator), .source_pulse(source_pulse),
      .port_c_change(port_c_change), .chip_reset(chip_reset),
      .irq_take(irq_take), .irq_vector(irq_vector),
      .hold_active(hold_active), .multi_function_output_pin(pin));
   twe_cpu cpu (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   always #2.5 pclk = ~pclk;
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic int t0_time(input logic [7:0] p, input logic sel);
      return (int'(p) + 1) * (sel ? 1024 : 4) + 1;
   endfunction
   function automatic int t1_gap(input logic [7:0] p, input logic div);
      return (int'(p) + 1) * (div ? 64 : 1);
   endfunction
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      rnd <= lfsr(rnd);
      mfp_generator <= rnd[5];
      sub_osc_clock <= rnd[9];
      port_c_change <= rnd[3:0];
      cyc++;
      if (irq_take === 1'b1)
         n_take++;
      if (chip_reset === 1'b1)
         n_rst++;
      if (cyc == 90000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d);
   endtask
   task automatic wait_for(input int which, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((which ? chip_reset : irq_take) !== 1'b1 && n < 17000);
   endtask
   task automatic pin_gap(output int n);
      logic last;
      last = pin;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pin === last && n < 20000);
   endtask
   initial begin
      int n, k;
      logic [7:0] p;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int s = 0; s < 2; s++) begin
         p = s ? {6'h0, rnd[1:0]} : rnd[7:0];
         wr(A_T0LOW, {28'h0, p[3:0]});
         wr(A_T0HIGH, {28'h0, p[7:4]});
         wr(A_IEF, 32'h2);
         wr(A_T0MODE, {28'h0, 3'b100, s[0]});
         wait_for(0, n);
         chk("t0 interval", n, t0_time(p, s[0]));
         chk("t0 vector", irq_vector, 8'h08);
         cpu.xfer(1'b0, A_STAT, 32'h0);
         chk("t0 stopped", {cpu.rdat[20], cpu.rdat[7:0]}, 9'h0ff);
      end
      $display("test timer0 done");
      for (int s = 0; s < 2; s++) begin
         p = s ? {4'h0, rnd[3:0]} : rnd[7:0];
         wr(A_T1LOW, {28'h0, p[3:0]});
         wr(A_T1HIGH, {28'h0, p[7:4]});
         wr(A_T1MODE, {28'h0, 3'b110, s[0]});
         pin_gap(n);
         pin_gap(n);
         pin_gap(n);
         chk("tone half period", n, t1_gap(p, s[0]));
      end
      wr(A_T0LOW, 32'hf);
      wr(A_T0HIGH, 32'hf);
      wr(A_T0MODE, 32'h8);
      wr(A_T0LOW, 32'h3);
      wr(A_T1LOW, 32'h5);
      cpu.xfer(1'b0, A_STAT, 32'h0);
      chk("load stops", cpu.rdat[21:20], 2'b00);
      $display("test timer1 done");
      wr(A_IEF, 32'h41);
      wr(A_CMD, 32'h4);
      wr(A_CMD, 32'h10);
      chk("hold entered", hold_active, 1'b1);
      k = n_take;
      source_pulse <= 5'b10001;
      @(posedge pclk);
      source_pulse <= 5'h00;
      repeat (8) @(posedge pclk);
      chk("masked", n_take - k, 0);
      wr(A_CMD, 32'h2);
      repeat (2) @(posedge pclk);
      chk("one take", n_take - k, 1);
      chk("lowest first", irq_vector, VEC_BASE);
      chk("hold left", hold_active, 1'b0);
      wr(A_CMD, 32'h8);
      chk("hold back", hold_active, 1'b1);
      wr(A_CMD, 32'h2);
      repeat (2) @(posedge pclk);
      chk("second vector", irq_vector, 8'h1c);
      cpu.xfer(1'b0, A_EVF, 32'h0);
      chk("port gated", cpu.rdat[2], 1'b0);
      wr(A_PEF, 32'hf);
      repeat (20) @(posedge pclk);
      cpu.xfer(1'b0, A_EVF, 32'h0);
      chk("port flag", cpu.rdat[2], 1'b1);
      $display("test interrupts done");
      cpu.xfer(1'b0, 8'h34, 32'h0);
      chk("unmapped err", cpu.rerr, 1'b1);
      chk("unmapped data", cpu.rdat, 32'h0);
      cpu.xfer(1'b0, A_T1MODE, 32'h0);
      chk("mode reads zero", cpu.rdat, 32'h0);
      $display("test registers done");
      watchdog_option <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         cpu.wd_clear();
         repeat (12000) @(posedge pclk);
      end
      chk("wd held off", n_rst, 0);
      cpu.wd_clear();
      wait_for(1, n);
      chk("wd window", n >= 15360 && n <= 16390, 1'b1);
      $display("test watchdog done");
      summarize();
   end
endmodule
bind twe_timers twe_checker u_twe_checker (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .watchdog_option(watchdog_option),
   .chip_reset(chip_reset), .irq_take(irq_take), .irq_vector(irq_vector),
   .hold_active(hold_active));
`default_nettype wire
